// [rsp_slave.sv]
// rtc side: serial slave, watchdog, reset override and register port
module rsp_slave
  import rsp_pkg::*;
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  // bus
  rsp_if.slave      bus,
  // rtc register file side
  input  wire logic [7:0]             i_rd_data,
  output logic      [WORD_ADDR_W-1:0] o_word_addr,
  output logic                        o_wr_valid,
  output logic      [7:0]             o_wr_data,
  input  wire logic                   i_wr_ready,
  // control bits held in the rtc control register
  input  wire logic i_override_permit_bit,
  input  wire logic i_ext_clock_test_select,
  // status
  output logic o_time_freeze,
  output logic o_lose_second,
  output logic o_core_reset,
  output logic o_external_clock_test_mode
);
  import rsp_pkg::*;
  typedef enum {S_IDLE, S_ADDR, S_WORD, S_WRITE, S_READ, S_IGNORE}
    rsp_slv_type;
  rsp_slv_type st_reg, st_next;
  logic [2:0] scl_sy, sda_sy;
  logic scl, sda, scl_p, sda_p, scl_rise, scl_fall, start, stop;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] bit_reg, bit_next;
  logic [WORD_ADDR_W-1:0] wa_reg, wa_next;
  logic oe_reg, oe_next, ack_reg, ack_next, rd_reg, rd_next;
  logic fv, fr;
  logic [7:0] fd;
  logic [31:0] sec_reg, sec_next;
  logic [1:0] wd_reg, wd_next;
  logic lose_reg, lose_next;
  logic [2:0] ov_step_reg, ov_step_next;
  logic [15:0] ov_cnt_reg, ov_cnt_next;
  logic ov_reg, ov_next, arm_reg, arm_next, por_reg, por_next;
  logic ext_reg;

  assign scl = scl_sy[1];
  assign sda = sda_sy[1];
  assign scl_p = scl_sy[2];
  assign sda_p = sda_sy[2];
  assign scl_rise = scl & ~scl_p;
  assign scl_fall = ~scl & scl_p;
  assign start = scl & scl_p & sda_p & ~sda;
  assign stop  = scl & scl_p & ~sda_p & sda;
  // data pin only; clock is never driven
  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = oe_reg;
  assign o_word_addr  = wa_reg;
  assign o_time_freeze = (st_reg != S_IDLE) && (st_reg != S_IGNORE);
  assign o_lose_second = lose_reg;
  assign o_core_reset  = por_reg;
  assign o_external_clock_test_mode = ext_reg;

  // write bytes queue toward the register file; stall is a late nack
  rsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_in_valid (fv),
    .i_in_data  (fd),
    .o_in_ready (fr),
    .o_out_valid(o_wr_valid),
    .o_out_data (o_wr_data),
    .i_out_ready(i_wr_ready)
  );

  always_comb begin
    st_next = st_reg; sh_next = sh_reg; bit_next = bit_reg;
    wa_next = wa_reg; oe_next = oe_reg; ack_next = ack_reg;
    rd_next = rd_reg; fv = 1'b0; fd = sh_reg;
    if (scl_rise && !ack_reg) begin
      sh_next  = {sh_reg[6:0], sda};
      bit_next = bit_reg + 4'h1;
    end
    if (scl_rise && ack_reg && st_reg == S_READ && sda) begin
      st_next = S_IGNORE;
    end
    if (scl_fall) begin
      oe_next = 1'b0;
      if (ack_reg) begin
        ack_next = 1'b0;
        bit_next = 4'h0;
        if (st_reg == S_READ) begin
          sh_next = i_rd_data;
          oe_next = ~i_rd_data[7];
          wa_next = wa_reg + 1'b1;
        end
      end else if (bit_reg == 4'h8) begin
        ack_next = 1'b1;
        unique case (st_reg)
          S_ADDR: if (sh_reg[7:1] == SLAVE_ADDR) begin
            oe_next = 1'b1;
            st_next = sh_reg[0] ? S_READ : S_WORD;
          end else st_next = S_IGNORE;
          S_WORD: begin
            oe_next = 1'b1;
            wa_next = sh_reg[WORD_ADDR_W-1:0];
            st_next = S_WRITE;
          end
          S_WRITE: begin
            fv = 1'b1;
            oe_next = fr;
            if (fr) wa_next = wa_reg + 1'b1;
          end
          // master owns the acknowledge slot after a read byte
          S_READ: oe_next = 1'b0;
          default: ack_next = 1'b0;
        endcase
        if (st_reg == S_READ) oe_next = 1'b0;
      end else if (st_reg == S_READ) begin
        // the shift on each rise brings the next bit to the top
        oe_next = ~sh_reg[7];
      end
      if (st_next == S_READ && st_reg == S_ADDR) rd_next = 1'b1;
    end
    if (start) begin
      st_next = S_ADDR; bit_next = 4'h0; ack_next = 1'b0; oe_next = 1'b0;
    end
    if (stop || wd_reg == 2'h2) begin
      st_next = S_IDLE; ack_next = 1'b0; oe_next = 1'b0;
    end
  end

  // coarse 1 Hz tick; watchdog counts ticks since the last start
  always_comb begin
    sec_next  = (sec_reg == 32'(TICK_CYC - 1)) ? 32'h0 : sec_reg + 32'h1;
    wd_next   = wd_reg;
    lose_next = 1'b0;
    if (!o_time_freeze || start || stop) wd_next = 2'h0;
    else if (sec_reg == 32'h0 && wd_reg != 2'h2) wd_next = wd_reg + 2'h1;
    if (wd_reg == 2'h2) begin
      wd_next = 2'h0;
      lose_next = 1'b1;
    end
  end

  // reset override: configurable line pattern, held per step
  always_comb begin
    ov_step_next = ov_step_reg;
    ov_cnt_next  = ov_cnt_reg;
    ov_next      = ov_reg;
    arm_next     = arm_reg | i_override_permit_bit;
    por_next     = por_reg;
    if ({scl, sda} == OVR_PATTERN[2*ov_step_reg[1:0] +: 2]) begin
      if (ov_cnt_reg != 16'(OVR_STEP_CYC)) ov_cnt_next = ov_cnt_reg + 16'h1;
    end else if (ov_cnt_reg == 16'(OVR_STEP_CYC) &&
                 {scl, sda} == OVR_PATTERN[2*(ov_step_reg[1:0]+2'h1) +: 2]
                 && ov_step_reg != 3'(OVR_STEPS - 1)) begin
      ov_step_next = ov_step_reg + 3'h1;
      ov_cnt_next  = 16'h0;
    end else begin
      ov_step_next = 3'h0;
      ov_cnt_next  = 16'h0;
    end
    if (ov_step_reg == 3'(OVR_STEPS - 1) &&
        ov_cnt_reg == 16'(OVR_STEP_CYC) && arm_reg && i_override_permit_bit)
    begin
      ov_next = 1'b1; por_next = 1'b0; arm_next = 1'b0;
    end
    if (!i_override_permit_bit) begin
      ov_next  = 1'b0;
      arm_next = 1'b0;
    end
    if (ov_reg || !o_time_freeze) por_next = 1'b0;
  end

  always_ff @(posedge i_sys_clk) begin
    scl_sy <= {scl_sy[1:0], bus.scl};
    sda_sy <= {sda_sy[1:0], bus.sda};
    ext_reg <= i_ext_clock_test_select & ~por_reg;
    if (!i_nrst) begin
      st_reg <= S_IDLE; sh_reg <= '0; bit_reg <= '0; wa_reg <= '0;
      oe_reg <= 1'b0; ack_reg <= 1'b0; rd_reg <= 1'b0;
      sec_reg <= '0; wd_reg <= '0; lose_reg <= 1'b0;
      ov_step_reg <= '0; ov_cnt_reg <= '0; ov_reg <= 1'b0;
      arm_reg <= PERMIT_RST; por_reg <= 1'b1;
    end else begin
      st_reg <= st_next; sh_reg <= sh_next; bit_reg <= bit_next;
      wa_reg <= wa_next; oe_reg <= oe_next; ack_reg <= ack_next;
      rd_reg <= rd_next; sec_reg <= sec_next; wd_reg <= wd_next;
      lose_reg <= lose_next; ov_step_reg <= ov_step_next;
      ov_cnt_reg <= ov_cnt_next; ov_reg <= ov_next;
      arm_reg <= arm_next; por_reg <= por_next;
    end
  end
endmodule // rsp_slave

// [rsp_pkg.sv]
// package of constants for the two-wire rtc serial slave port
// Function
// - outside party toggles lines in fixed order
// - recognised sequence releases reset at once
// - writing zero to permit bit clears override
// - re-entry needs permit bit set back
// - clearing permit blocks override entry and clears override
// - master starts only on idle bus
// - one bit per clock, data stable high
// - idle bus leaves both lines high
// - start and stop detected on data edges
// - every byte followed by acknowledge slot
// - receiver pulls data low during acknowledge
// - master nacks last byte, slave releases
// - address byte first after every start
// - slave only, clock input, data bidirectional
// - low four word address bits select
// - time counting frozen during access
// - stalled access over one second cleared
// - start or stop clears the watchdog
// - watchdog fires one to two seconds
// - each timeout loses exactly one second
// - test select turns clock pin input
package rsp_pkg;
  localparam logic [6:0] SLAVE_ADDR    = 7'h51;
  localparam int         WORD_ADDR_W   = 4;
  localparam int         SYS_CLK_HZ    = 40000000;
  localparam int         LINK_PERIOD_NS = 200;
  localparam int         SYS_PERIOD_NS = 1000000000 / SYS_CLK_HZ;
  // master clock divider: half link period in system cycles
  localparam int         HALF_LINK_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  // one second tick, exact: TICK_S times the system clock rate
  localparam int         TICK_S        = 1;
  localparam int         TICK_CYC      = TICK_S * SYS_CLK_HZ;
  // override sequence: each step held at least this long
  localparam int         OVR_STEP_NS   = 1000;
  localparam int         OVR_STEP_CYC  =
    (OVR_STEP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int         OVR_STEPS     = 4;
  // line levels {scl,sda} per step; both high is idle
  localparam logic [7:0] OVR_PATTERN   = 8'h1E; // 10,11,01,00 from step 0
  localparam int         FIFO_DEPTH    = 8;
  localparam logic       PERMIT_RST    = 1'b1;
endpackage

// [rsp_if.sv]
// interface joining the bus master and the rtc serial slave port
interface rsp_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // open drain wire levels
  logic scl;
  logic sda;
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe,
                  input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// [rsp_fifo.sv]
// valid/ready fifo with parameter width and depth
module rsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
  logic             push, pop;

  always_comb begin
    o_in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    o_out_valid = wr_reg != rd_reg;
    o_out_data  = mem_reg[rd_reg[AW-1:0]];
    push        = i_in_valid & o_in_ready;
    pop         = o_out_valid & i_out_ready;
    wr_next     = wr_reg + (AW+1)'(push);
    rd_next     = rd_reg + (AW+1)'(pop);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= i_in_data;
    end
  end
endmodule // rsp_fifo

// [rsp_master.sv]
// bus master end: byte transfers driven from a command port
module rsp_master
  import rsp_pkg::*;
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  // bus
  rsp_if.master     bus,
  // command: {start before, stop after, read, ack to send}
  input  wire logic       i_cmd_valid,
  input  wire logic [3:0] i_cmd_op,
  input  wire logic [7:0] i_cmd_data,
  output logic            o_cmd_ready,
  // result
  output logic            o_res_valid,
  output logic [7:0]      o_res_data,
  output logic            o_res_nack
);
  import rsp_pkg::*;
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} rsp_mst_type;
  rsp_mst_type st_reg, st_next;
  logic [3:0]  op_reg, op_next;
  logic [7:0]  sh_reg, sh_next;
  logic [3:0]  bit_reg, bit_next;
  logic [1:0]  ph_reg, ph_next;
  logic [7:0]  div_reg, div_next;
  logic        scl_reg, scl_next, sda_reg, sda_next;
  logic        rv_reg, rv_next, nk_reg, nk_next;
  logic        sda_s1, sda_s2;
  logic        tick;

  assign bus.scl_o    = scl_reg;
  assign bus.scl_oe   = ~scl_reg;
  assign bus.sda_m_o  = sda_reg;
  assign bus.sda_m_oe = ~sda_reg;
  assign o_cmd_ready  = (st_reg == M_IDLE);
  assign o_res_valid  = rv_reg;
  assign o_res_data   = sh_reg;
  assign o_res_nack   = nk_reg;

  always_comb begin
    st_next  = st_reg;
    op_next  = op_reg;
    sh_next  = sh_reg;
    bit_next = bit_reg;
    ph_next  = ph_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    nk_next  = nk_reg;
    rv_next  = 1'b0;
    tick     = div_reg == 8'(HALF_LINK_CYC / 2 - 1);
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    unique case (st_reg)
      M_IDLE: begin
        div_next = 8'h00;
        if (i_cmd_valid) begin
          op_next  = i_cmd_op;
          sh_next  = i_cmd_op[1] ? 8'hFF : i_cmd_data;
          bit_next = 4'h0;
          ph_next  = 2'h0;
          st_next  = i_cmd_op[3] ? M_START : M_BIT;
        end
      end
      M_START: if (tick) begin
        ph_next = ph_reg + 2'h1;
        unique case (ph_reg)
          2'h0: begin sda_next = 1'b1; scl_next = 1'b1; end
          2'h1: sda_next = 1'b0;
          2'h2: scl_next = 1'b0;
          default: begin ph_next = 2'h0; st_next = M_BIT; end
        endcase
      end
      M_BIT: if (tick) begin
        ph_next = ph_reg + 2'h1;
        unique case (ph_reg)
          2'h0: sda_next = (bit_reg == 4'h8) ?
                  (op_reg[1] ? op_reg[0] : 1'b1) :
                  (op_reg[1] ? 1'b1 : sh_reg[7]);
          2'h1: scl_next = 1'b1;
          2'h2: begin
            if (bit_reg == 4'h8) nk_next = sda_s2;
            else sh_next = {sh_reg[6:0], sda_s2};
          end
          default: begin
            scl_next = 1'b0;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              rv_next = 1'b1;
              st_next = op_reg[2] ? M_STOP : M_IDLE;
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        ph_next = ph_reg + 2'h1;
        unique case (ph_reg)
          2'h0: sda_next = 1'b0;
          2'h1: scl_next = 1'b1;
          2'h2: sda_next = 1'b1;
          default: st_next = M_IDLE;
        endcase
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    sda_s1 <= bus.sda;
    sda_s2 <= sda_s1;
    if (!i_nrst) begin
      st_reg <= M_IDLE; op_reg <= '0; sh_reg <= '0; bit_reg <= '0;
      ph_reg <= '0; div_reg <= '0; scl_reg <= 1'b1; sda_reg <= 1'b1;
      rv_reg <= 1'b0; nk_reg <= 1'b0;
    end else begin
      st_reg <= st_next; op_reg <= op_next; sh_reg <= sh_next;
      bit_reg <= bit_next; ph_reg <= ph_next; div_reg <= div_next;
      scl_reg <= scl_next; sda_reg <= sda_next;
      rv_reg <= rv_next; nk_reg <= nk_next;
    end
  end
endmodule // rsp_master

// [rsp_checker.sv]
// bus-level checker for the two-wire link between master and slave
module rsp_checker
  import rsp_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // resolved wires and slave drive
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  logic       scl_reg, sda_reg, busy_reg, adr_reg, hit_reg, rd_reg;
  logic       scl_next, sda_next, busy_next, adr_next, hit_next, rd_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic       rise, start, stop;
  always_comb begin
    rise = scl & ~scl_reg;
    start = scl & scl_reg & sda_reg & ~sda;
    stop = scl & scl_reg & ~sda_reg & sda;
    scl_next = scl;
    sda_next = sda;
    busy_next = (busy_reg | start) & ~stop;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    adr_next = adr_reg;
    hit_next = hit_reg;
    rd_next = rd_reg;
    if (start) begin
      cnt_next = 4'h0;
      adr_next = 1'b1;
    end else if (rise && cnt_reg == 4'h8) begin
      cnt_next = 4'h0;
      adr_next = 1'b0;
      if (adr_reg) begin
        hit_next = sh_reg[7:1] == SLAVE_ADDR;
        rd_next = sh_reg[0];
      end
    end else if (rise) begin
      cnt_next = cnt_reg + 4'h1;
      sh_next = {sh_reg[6:0], sda};
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      {scl_reg, sda_reg, busy_reg, adr_reg, hit_reg, rd_reg} <= 6'h30;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
    end else begin
      {scl_reg, sda_reg, busy_reg} <= {scl_next, sda_next, busy_next};
      {adr_reg, hit_reg, rd_reg} <= {adr_next, hit_next, rd_next};
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // ninth rising clock of a byte: the acknowledge slot
  sequence s_slot;
    rise && cnt_reg == 4'h8;
  endsequence
  // high phase lasts four system cycles with the package divider
  a_addr_ack: assert property ((s_slot ##0 (adr_reg &&
    sh_reg[7:1] == SLAVE_ADDR)) |-> !sda [*4])
    else $error("own address not acknowledged");
  a_miss_quiet: assert property ((s_slot ##0 (adr_reg &&
    sh_reg[7:1] != SLAVE_ADDR)) |-> !sda_s_oe [*4])
    else $error("foreign address acknowledged");
  a_foreign_quiet: assert property (busy_reg && !adr_reg &&
    !hit_reg |-> !sda_s_oe)
    else $error("slave drives in a foreign transfer");
  a_read_release: assert property ((s_slot ##0 (!adr_reg &&
    rd_reg && hit_reg)) |-> !sda_s_oe)
    else $error("slave drives the master acknowledge slot");
  a_idle_high: assert property (!busy_reg && !start |-> scl && sda)
    else $error("line low on idle bus");
  a_idle_free: assert property (!busy_reg |-> !sda_s_oe)
    else $error("slave drives idle bus");
  a_open_drain: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives data high");
  a_hold_high: assert property (scl && scl_reg |-> $stable(sda_s_oe))
    else $error("slave data changed while clock high");
  a_scl_width: assert property (rise && busy_reg |-> scl [*4])
    else $error("clock high phase too short");
endmodule // rsp_checker

// [tb.sv]
// self-checking bench for the master and slave ends of the link
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsp_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [3:0] cmd_op = 4'h0;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] rd_data = 8'h00;
  logic       wr_ready = 1'b0;
  logic       tsel = 1'b0;
  logic       stall = 1'b0;
  logic       cmd_ready, res_valid, res_nack, wr_valid;
  logic       freeze, lose, core_rst, ext_mode;
  logic [7:0] res_data, wr_data;
  logic [3:0] word_addr;
  logic [31:0] lfsr = 32'h666BD395;
  logic [31:0] dlfsr = 32'h666BD395;
  logic [7:0] exp_q[$];
  int         n_mismatch = 0;
  int         n_compared = 0;
  always #12.5 clk = ~clk;
  rsp_if bus_if ();
  rsp_master i_rsp_master (.i_sys_clk(clk), .i_nrst(nrst), .bus(bus_if),
    .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_data(cmd_data),
    .o_cmd_ready(cmd_ready), .o_res_valid(res_valid),
    .o_res_data(res_data), .o_res_nack(res_nack));
  // permit bit tied: override entry needs the master to bit-bang lines
  rsp_slave i_rsp_slave (.i_sys_clk(clk), .i_nrst(nrst), .bus(bus_if),
    .i_rd_data(rd_data), .o_word_addr(word_addr), .o_wr_valid(wr_valid),
    .o_wr_data(wr_data), .i_wr_ready(wr_ready),
    .i_override_permit_bit(1'b1), .i_ext_clock_test_select(tsel),
    .o_time_freeze(freeze), .o_lose_second(lose), .o_core_reset(core_rst),
    .o_external_clock_test_mode(ext_mode));
  rsp_checker i_rsp_checker (.i_sys_clk(clk), .i_nrst(nrst),
    .scl(bus_if.scl), .sda(bus_if.sda), .sda_s_o(bus_if.sda_s_o),
    .sda_s_oe(bus_if.sda_s_oe));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] rd_fn(input logic [3:0] a);
    return {a, ~a};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one byte command; returns at the edge that shows the result
  task automatic xfer(input logic [3:0] op, input logic [7:0] d);
    int n;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    @(posedge clk);
    for (n = 0; n < 99 && cmd_ready !== 1'b1; n++) @(posedge clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 999 && res_valid !== 1'b1; n++) @(posedge clk);
  endtask
  task automatic ack(input logic exp);
    check({7'h00, res_nack}, {7'h00, exp});
  endtask
  // drain side stalls at random; read data follows the word address
  always @(posedge clk) begin
    dlfsr <= nxt(dlfsr);
    wr_ready <= ~stall & dlfsr[0];
    rd_data <= rd_fn(word_addr);
    if (lose === 1'b1)
      check(8'h01, 8'h00);
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      check(wr_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
  end
  initial begin
    logic [3:0] wa;
    logic [6:0] ba;
    int         k;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    lfsr = nxt(lfsr);
    wa = lfsr[3:0];
    xfer(4'h8, {SLAVE_ADDR, 1'b0});
    ack(1'b0);
    xfer(4'h0, {lfsr[7:4], wa});
    ack(1'b0);
    check({7'h00, freeze}, 8'h01);
    for (k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      exp_q.push_back(lfsr[15:8]);
      xfer(k == 3 ? 4'h4 : 4'h0, lfsr[15:8]);
      ack(1'b0);
    end
    repeat (40) @(posedge clk);
    check({6'h00, freeze, core_rst}, 8'h00);
    $display("write burst done");
    xfer(4'h8, {SLAVE_ADDR, 1'b1});
    ack(1'b0);
    wa = wa + 4'h4;
    for (k = 0; k < 3; k++) begin
      xfer(k == 2 ? 4'h7 : 4'h2, 8'hFF);
      check(res_data, rd_fn(wa));
      wa = wa + 4'h1;
    end
    lfsr = nxt(lfsr);
    xfer(4'h8, {SLAVE_ADDR, 1'b0});
    xfer(4'h0, lfsr[7:0]);
    xfer(4'h8, {SLAVE_ADDR, 1'b1});
    xfer(4'h7, 8'hFF);
    check(res_data, rd_fn(lfsr[3:0]));
    $display("read back done");
    for (k = 0; k < 5; k++) begin
      lfsr = nxt(lfsr);
      ba = k == 0 ? SLAVE_ADDR ^ 7'h01 : lfsr[6:0];
      if (ba == SLAVE_ADDR)
        ba = ba ^ 7'h40;
      xfer(4'hC, {ba, lfsr[7]});
      ack(1'b1);
    end
    $display("foreign address done");
    stall <= 1'b1;
    for (k = 0; k < 999 && exp_q.size() > 0; k++) @(posedge clk);
    xfer(4'h8, {SLAVE_ADDR, 1'b0});
    xfer(4'h0, 8'h00);
    for (k = 0; k < FIFO_DEPTH + 1; k++) begin
      lfsr = nxt(lfsr);
      if (k < FIFO_DEPTH)
        exp_q.push_back(lfsr[7:0]);
      xfer(k == FIFO_DEPTH ? 4'h4 : 4'h0, lfsr[7:0]);
      ack(k == FIFO_DEPTH);
    end
    stall <= 1'b0;
    for (k = 0; k < 999 && exp_q.size() > 0; k++) @(posedge clk);
    check(8'(exp_q.size()), 8'h00);
    $display("buffer full done");
    tsel <= 1'b1;
    repeat (4) @(posedge clk);
    check({7'h00, ext_mode}, 8'h01);
    $display("test clock select done");
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb
